//--- src/crs_pkg.sv
// Constants, states and bundles shared by the chip reset sequencer.
// Assumes the consumers of the reset bundle apply these values themselves.
`default_nettype none
package crs_pkg;

  // ==========================================================
  // Start-up delay
  localparam int STARTUP_CYCLES = 1024;
  localparam logic [9:0] STARTUP_LAST = 10'(STARTUP_CYCLES - 1);

  // ==========================================================
  // Register values loaded on a full chip reset; synth channel select only on power-on reset
  localparam logic [7:0] WATCHDOG_SELECT_RST = 8'h07;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_RST = 8'h08;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [5:0] SYNTH_CHANNEL_SELECT_RST = 6'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [2:0] SP_RST = 3'h0;
  // Warm reset: only this timer control bit is forced high
  localparam int TIMER_EDGE_BIT = 3;
  localparam logic [7:0] TIMER_CONTROL_WARM_SET = 8'h08;

  // ==========================================================
  // Sequencer states and reset causes
  typedef enum logic [2:0] {
    ST_RUN,
    ST_PIN,
    ST_DELAY,
    ST_RELEASE
  } crs_state_t;

  typedef enum logic [2:0] {
    CAUSE_POR,
    CAUSE_PIN_RUN,
    CAUSE_PIN_HALT,
    CAUSE_WDT_RUN,
    CAUSE_WDT_HALT,
    CAUSE_WAKE
  } crs_cause_t;

  // ==========================================================
  // Reset control bundle towards CPU and peripherals
  typedef struct packed {
    logic chipReset;
    logic porReset;
    logic warmReset;
    logic cpuHold;
    logic wdtClear;
  } crs_ctl_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } crs_flags_t;

endpackage : crs_pkg
`default_nettype wire

//--- src/crs_chip_reset_sequencer.sv
// Chip reset sequencer: reset causes, cause flags, start-up delay.
// Assumes halt and watchdog logic give one-cycle pulses on ref_clk.
// Overview of operation
// R1 - Three full reset sources: pin running, pin halted, watchdog running.
// R2 - Watchdog while halted only clears program counter and stack pointer.
// R3 - Warm reset keeps all else, forcing timer control bit 3 high.
// R4 - Full reset loads defined values; undefined registers keep contents.
// R5 - Time-out and power-down flags are readable by software.
// R6 - Flags: 00 power-up, uu pin run, 01 pin halt, 1u wdt, 11.
// R7 - Start-up delay of 1024 clocks after power-up and halt exit.
// R8 - Pin reset while not halted skips the start-up delay.
// R9 - Every wake from halt applies the start-up delay.
// R10 - Full reset loads watchdog select, interrupt, timer, port defaults.
// R11 - Synth channel select clears only on power-on reset.
// R12 - Reset disables interrupts, clears watchdog; it restarts on release.
// R13 - Reset sets stack top, stops timers, ports to input.
// R14 - Watchdog overflow when running gives full reset, sets time-out.
// R15 - Power-down flag cleared by power-up, watchdog clear; set by halt.
// R16 - Reset pin is synchronised; reset held until delay elapsed.
// R17 - Cause flags update when reset is released.
`timescale 1ns/1ps
`default_nettype none
module crs_chip_reset_sequencer
  import crs_pkg::*;
(
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Reset pin and wake sources
  input wire logic ext_reset_n,
  input wire logic halted,
  input wire logic wdtTimeout,
  // Instruction events
  input wire logic haltExec,
  input wire logic wdtClearExec,
  // Reset controls
  output var crs_ctl_t resetCtl,
  output var logic [7:0] timerControlSet,
  // Cause flags
  output var crs_flags_t flags
);

  // ==========================================================
  // Reset pin synchroniser
  logic pinMeta;
  logic pinSync;

  // R16 two-stage synchroniser
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= ext_reset_n;
      pinSync <= pinMeta;
    end
  end

  wire logic pinLow = !pinSync;

  // ==========================================================
  // Halt exit detection
  logic haltedPrev;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      haltedPrev <= 1'b0;
    end else begin
      haltedPrev <= halted;
    end
  end

  wire logic wakeEdge = haltedPrev && !halted;

  // ==========================================================
  // Sequencer state
  crs_state_t state;
  crs_state_t next_state;
  crs_cause_t cause;
  crs_cause_t next_cause;
  logic [9:0] count;
  logic [9:0] next_count;

  // Causes seen while running
  wire logic inRun = (state == ST_RUN);
  // R1 pin reset sources
  wire logic pinEvent = inRun && pinLow;
  // R14 watchdog while running
  wire logic wdtRunEvent = inRun && !pinLow && wdtTimeout && !halted;
  // R2 watchdog while halted
  wire logic wdtHaltEvent = inRun && !pinLow && wdtTimeout && halted;
  // R9 any other halt exit
  wire logic wakeEvent = inRun && !pinLow && !wdtTimeout && wakeEdge;
  wire logic delayDone = (state == ST_DELAY) && (count == 10'h000);

  // Next state; pin outranks watchdog since it also clears the watchdog
  always_comb begin
    next_state = state;
    next_cause = cause;
    next_count = count;
    unique case (state)
      ST_RUN: begin
        if (pinEvent) begin
          next_state = ST_PIN;
          next_cause = halted ? CAUSE_PIN_HALT : CAUSE_PIN_RUN;
        end else if (wdtRunEvent) begin
          // R14 full reset, no oscillator restart so no delay
          next_state = ST_RELEASE;
          next_cause = CAUSE_WDT_RUN;
        end else if (wdtHaltEvent || wakeEvent) begin
          // R9 wake delay
          next_state = ST_DELAY;
          next_cause = wdtHaltEvent ? CAUSE_WDT_HALT : CAUSE_WAKE;
          next_count = STARTUP_LAST;
        end
      end
      ST_PIN: begin
        if (!pinLow) begin
          // R8 no delay unless leaving halt
          next_state = (cause == CAUSE_PIN_HALT) ? ST_DELAY : ST_RELEASE;
          next_count = STARTUP_LAST;
        end
      end
      ST_DELAY: begin
        // R7 count out start-up delay
        if (delayDone) begin
          next_state = ST_RELEASE;
        end else begin
          next_count = count - 10'h001;
        end
      end
      ST_RELEASE: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Power-up starts in the delay as a power-on cause
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_DELAY;
      cause <= CAUSE_POR;
      count <= STARTUP_LAST;
    end else begin
      state <= next_state;
      cause <= next_cause;
      count <= next_count;
    end
  end

  // ==========================================================
  // Reset control outputs
  wire logic fullCause = (next_cause == CAUSE_POR) || (next_cause == CAUSE_PIN_RUN) ||
                         (next_cause == CAUSE_PIN_HALT) || (next_cause == CAUSE_WDT_RUN);
  wire logic nextBusy = (next_state != ST_RUN);
  crs_ctl_t next_ctl;

  always_comb begin
    // R16 hold chip reset to the end of the delay for full-reset causes only; wake delays hold cpuHold alone
    next_ctl.chipReset = nextBusy && fullCause;
    // R11 channel select clears on power-on only
    next_ctl.porReset = nextBusy && (next_cause == CAUSE_POR);
    // R2 one pulse clearing PC and SP
    next_ctl.warmReset = wdtHaltEvent;
    // R9 execution held during delay
    next_ctl.cpuHold = nextBusy;
    // R12 watchdog cleared in reset, counts after release
    next_ctl.wdtClear = next_ctl.chipReset;
  end

  // R3 timer edge bit forced with the warm pulse
  wire logic [7:0] next_timerSet = wdtHaltEvent ? TIMER_CONTROL_WARM_SET : 8'h00;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      resetCtl <= '{chipReset: 1'b1, porReset: 1'b1, warmReset: 1'b0,
                    cpuHold: 1'b1, wdtClear: 1'b1};
      timerControlSet <= 8'h00;
    end else begin
      // R4 R10 R13 consumers load defaults while chipReset
      resetCtl <= next_ctl;
      timerControlSet <= next_timerSet;
    end
  end

  // ==========================================================
  // Cause flags
  crs_flags_t next_flags;
  wire logic releasing = (state == ST_RELEASE);

  always_comb begin
    next_flags = flags;
    if (releasing) begin
      // R17 R6 final values at release
      unique case (cause)
        CAUSE_POR: next_flags = '{timeout_flag: 1'b0, powerdown_flag: 1'b0};
        CAUSE_PIN_HALT: next_flags = '{timeout_flag: 1'b0, powerdown_flag: 1'b1};
        CAUSE_WDT_RUN: next_flags.timeout_flag = 1'b1;
        CAUSE_WDT_HALT: next_flags = '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
        default: next_flags = flags;
      endcase
    end else if (inRun) begin
      // R15 halt sets, clear instruction clears; set wins
      if (wdtClearExec) begin
        next_flags.powerdown_flag = 1'b0;
      end
      if (haltExec) begin
        next_flags.powerdown_flag = 1'b1;
        next_flags.timeout_flag = 1'b0;
      end
    end
  end

  // R5 flags straight from flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags <= '{timeout_flag: 1'b0, powerdown_flag: 1'b0};
    end else begin
      flags <= next_flags;
    end
  end

  // ==========================================================
  // Checks
  property p_delayLen;
    @(posedge ref_clk) disable iff (!resetn)
    (inRun && wakeEvent) |=> (state == ST_DELAY)[*8] ##1 1'b1;
  endproperty
  a_delayLen: assert property (p_delayLen) else $error("delay ended early"); // R7

  property p_pinNoDelay;
    @(posedge ref_clk) disable iff (!resetn)
    (state == ST_PIN && !pinLow && cause == CAUSE_PIN_RUN) |=> (state == ST_RELEASE);
  endproperty
  a_pinNoDelay: assert property (p_pinNoDelay) else $error("pin reset delayed"); // R8

  property p_warmOnly;
    @(posedge ref_clk) disable iff (!resetn)
    wdtHaltEvent |=> resetCtl.warmReset && !resetCtl.chipReset && timerControlSet[3];
  endproperty
  a_warmOnly: assert property (p_warmOnly) else $error("warm reset wrong"); // R2

  property p_wdtRunFlag;
    @(posedge ref_clk) disable iff (!resetn)
    wdtRunEvent |=> resetCtl.chipReset ##1 flags.timeout_flag;
  endproperty
  a_wdtRunFlag: assert property (p_wdtRunFlag) else $error("wdt flag not set"); // R14

  property p_haltSets;
    @(posedge ref_clk) disable iff (!resetn)
    (inRun && haltExec) |=> flags.powerdown_flag && !flags.timeout_flag;
  endproperty
  a_haltSets: assert property (p_haltSets) else $error("halt flag wrong"); // R15

  property p_pinHaltFlags;
    @(posedge ref_clk) disable iff (!resetn)
    (releasing && cause == CAUSE_PIN_HALT) |=> flags == 2'b01;
  endproperty
  a_pinHaltFlags: assert property (p_pinHaltFlags) else $error("pin halt flags"); // R6

  property p_holdInDelay;
    @(posedge ref_clk) disable iff (!resetn)
    (state == ST_DELAY) |=> resetCtl.cpuHold;
  endproperty
  a_holdInDelay: assert property (p_holdInDelay) else $error("hold dropped"); // R16

  property p_porOnly;
    @(posedge ref_clk) disable iff (!resetn)
    resetCtl.porReset |-> $past(cause) == CAUSE_POR || $past(next_cause) == CAUSE_POR;
  endproperty
  a_porOnly: assert property (p_porOnly) else $error("channel cleared"); // R11

  property p_flagsStable;
    @(posedge ref_clk) disable iff (!resetn)
    (!releasing && !inRun) |=> $stable(flags);
  endproperty
  a_flagsStable: assert property (p_flagsStable) else $error("flags moved"); // R17

  // Independent tally of delay cycles, so a wrong count load is caught
  // R7 delay length tally
  logic [10:0] delaySpan;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      delaySpan <= 11'h000;
    end else if (state == ST_DELAY) begin
      delaySpan <= delaySpan + 11'h001;
    end else begin
      delaySpan <= 11'h000;
    end
  end

  property p_delaySpan;
    @(posedge ref_clk) disable iff (!resetn)
    (state == ST_DELAY && next_state == ST_RELEASE) |-> delaySpan == {1'b0, STARTUP_LAST};
  endproperty
  a_delaySpan: assert property (p_delaySpan) else $error("delay length wrong"); // R7

  property p_porWithChip;
    @(posedge ref_clk) disable iff (!resetn)
    resetCtl.porReset |-> resetCtl.chipReset;
  endproperty
  a_porWithChip: assert property (p_porWithChip) else $error("por without chip reset"); // R4

  property p_warmPulse;
    @(posedge ref_clk) disable iff (!resetn)
    resetCtl.warmReset |=> !resetCtl.warmReset;
  endproperty
  a_warmPulse: assert property (p_warmPulse) else $error("warm pulse too long"); // R2

  property p_wakeKeeps;
    @(posedge ref_clk) disable iff (!resetn)
    (state == ST_DELAY && (cause == CAUSE_WDT_HALT || cause == CAUSE_WAKE))
      |-> !resetCtl.chipReset;
  endproperty
  a_wakeKeeps: assert property (p_wakeKeeps) else $error("wake gave chip reset"); // R3

  property p_pinRunFlags;
    @(posedge ref_clk) disable iff (!resetn)
    (releasing && cause == CAUSE_PIN_RUN) |=> $stable(flags);
  endproperty
  a_pinRunFlags: assert property (p_pinRunFlags) else $error("pin run moved flags"); // R6

endmodule : crs_chip_reset_sequencer
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the chip reset sequencer: a table of reset events, then power-on.
// Assumes every output of the sequencer is registered on the rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module tb_top import crs_pkg::*;;
  // ==========================================================
  // Stimulus, outputs and event table
  typedef struct {
    int ev; // 0 watchdog, 1 pin, 2 wake, 3 watchdog clear
    logic hlt;
    logic [1:0] expFlags;
    int minHold;
    int maxHold;
    logic expChip;
  } crs_row_t;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic ext_reset_n = 1'h1;
  logic halted = 1'h0;
  logic wdtTimeout = 1'h0;
  logic haltExec = 1'h0;
  logic wdtClearExec = 1'h0;
  crs_ctl_t resetCtl;
  logic [7:0] timerControlSet;
  crs_flags_t flags;
  int fail_count = 0;
  int tests_run = 0;
  // Counts: 0 hold, 1 warm, 2 chip, 3 power-on, 4 clear mismatch, 5 edge bit, 6 bad set
  int histNow[7] = '{default: 0};
  int histBase[7] = '{default: 0};
  crs_row_t rows[6] = '{
    '{0, 1'h0, 2'h2, 1, 4, 1'h1},
    '{1, 1'h0, 2'h2, 1, 12, 1'h1},
    '{1, 1'h1, 2'h1, 1024, 1040, 1'h1},
    '{0, 1'h1, 2'h3, 1024, 1040, 1'h0},
    '{2, 1'h1, 2'h1, 1024, 1040, 1'h0},
    '{3, 1'h0, 2'h0, 0, 0, 1'h0}};

  crs_chip_reset_sequencer crs_chip_reset_sequencer_i (
    .ref_clk(ref_clk), .resetn(resetn), .ext_reset_n(ext_reset_n), .halted(halted),
    .wdtTimeout(wdtTimeout), .haltExec(haltExec), .wdtClearExec(wdtClearExec),
    .resetCtl(resetCtl), .timerControlSet(timerControlSet), .flags(flags));

  // Clock, 8 ns period
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Output history; tasks snapshot it rather than clear it, so only this process writes it
  always @(posedge ref_clk) begin
    histNow[0] <= histNow[0] + int'(resetCtl.cpuHold === 1'h1);
    histNow[1] <= histNow[1] + int'(resetCtl.warmReset === 1'h1);
    histNow[2] <= histNow[2] + int'(resetCtl.chipReset === 1'h1);
    histNow[3] <= histNow[3] + int'(resetCtl.porReset === 1'h1);
    histNow[4] <= histNow[4] + int'(resetCtl.wdtClear !== resetCtl.chipReset);
    histNow[5] <= histNow[5] + int'(timerControlSet === 8'h08);
    histNow[6] <= histNow[6] + int'(timerControlSet !== 8'h08 && timerControlSet !== 8'h00);
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic clear_history();
    histBase = histNow;
  endtask : clear_history

  // Count of one history entry since the last snapshot
  function automatic int seen(input int k);
    return histNow[k] - histBase[k];
  endfunction : seen

  // Bounded wait for the end of the hold, then one settling cycle
  task automatic wait_hold();
    int n;
    n = 0;
    while (resetCtl.cpuHold !== 1'h0 && n < 1100) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    check("holdEnds", 1'h0, resetCtl.cpuHold);
  endtask : wait_hold

  task automatic reset_seq();
    resetn = 1'h0;
    repeat (5) @(negedge ref_clk);
    check("ctlInReset", 5'h1b, resetCtl);
    check("flagsInReset", 2'h0, flags);
    check("tcsInReset", 8'h00, timerControlSet);
    clear_history();
    resetn = 1'h1;
    wait_hold();
    check("porHold", 1'h1, seen(0) >= 1024 && seen(0) <= 1030);
    check("porFlags", 2'h0, flags);
    check("porSeen", 1'h1, seen(3) != 0);
    check("porReleased", 2'h0, {resetCtl.chipReset, resetCtl.porReset});
  endtask : reset_seq

  task automatic run_row(input crs_row_t r);
    if (r.hlt) begin
      haltExec = 1'h1;
      @(negedge ref_clk);
      haltExec = 1'h0;
      halted = 1'h1;
      repeat (2) @(negedge ref_clk);
    end
    clear_history();
    case (r.ev)
      0: wdtTimeout = 1'h1;
      1: ext_reset_n = 1'h0;
      2: halted = 1'h0;
      default: wdtClearExec = 1'h1;
    endcase
    @(negedge ref_clk);
    wdtTimeout = 1'h0;
    wdtClearExec = 1'h0;
    // Pin held low four cycles in all, past the two-flop synchroniser
    repeat (3) @(negedge ref_clk);
    ext_reset_n = 1'h1;
    halted = 1'h0;
    wait_hold();
    check("flags", r.expFlags, flags);
    check("holdInRange", 1'h1, seen(0) >= r.minHold && seen(0) <= r.maxHold);
    check("chipReset", r.expChip, seen(2) != 0);
    check("warmPulse", (r.ev == 0 && r.hlt) ? 1 : 0, seen(1));
    check("timerSet", (r.ev == 0 && r.hlt) ? 1 : 0, seen(5));
    check("timerOther", 0, seen(6));
    check("porOnlyAtPowerOn", 1'h0, seen(3) != 0);
    check("wdtClearFollows", 1'h0, seen(4));
  endtask : run_row

  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Main sequence: power-on, event table, then a reset in mid-run
  initial begin
    @(negedge ref_clk);
    reset_seq();
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    // Halt and clear in one cycle: the halt must win
    haltExec = 1'h1;
    wdtClearExec = 1'h1;
    @(negedge ref_clk);
    haltExec = 1'h0;
    wdtClearExec = 1'h0;
    @(negedge ref_clk);
    check("haltBeatsClear", 2'h1, flags);
    wdtClearExec = 1'h1;
    @(negedge ref_clk);
    wdtClearExec = 1'h0;
    @(negedge ref_clk);
    check("clearDropsPd", 2'h0, flags);
    // Power-down flag set first, so power-on must clear it
    haltExec = 1'h1;
    @(negedge ref_clk);
    haltExec = 1'h0;
    @(negedge ref_clk);
    check("haltSetsFlag", 2'h1, flags);
    // Pin and watchdog reach the sequencer at one edge: pin wins, flags stay
    ext_reset_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    wdtTimeout = 1'h1;
    @(negedge ref_clk);
    wdtTimeout = 1'h0;
    ext_reset_n = 1'h1;
    wait_hold();
    check("pinBeatsWatchdog", 2'h1, flags);
    reset_seq();
    give_verdict();
  end

  // Watchdog: the whole run needs well under 10000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
